// >>> src/ims_master.sv
// two-wire bus master sequencer with classic wishbone register slave
// Operation
// - start samples both lines, then reloads baud
// - timeout with lines high drives start edge
// - second timeout clears start request, SCL low
// - line low during start sets bus collision
// - buffer write while busy is dropped, sets write_collision_flag
// - write collision cleared only by software
// - low five control bits locked during start
// - restart request honoured only when idle
// - restart pulls SCL low, then releases SDA
// - SCL released, high period, then SDA low
// - restart ends without reload, flag after timeout
// - restart collision on SDA low or SCL fall
// - buffer write sets full and starts shifting
// - SDA changes after SCL falls, low/high periods
// - eighth falling edge clears full, frees SDA
// - ninth clock samples acknowledge into status
// - after ninth clock flag set, SCL held low
// - receive toggles SCL per rollover, shifts SDA
// - eighth receive bit loads buffer, flags, idles
// - reading received buffer clears full flag
// - byte completing while full sets overflow
`timescale 1ns/1ps
module ims_master (
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sclIn,
  output logic             sclOut,
  output logic             sclOe,
  input  wire logic        sdaIn,
  output logic             sdaOut,
  output logic             sdaOe
);
  ims_pkg::ims_regs_t q_ff;
  ims_pkg::ims_regs_t nxt_q;
  logic               sclS;
  logic               sdaS;
  logic               req;
  logic               wr;
  logic               rd;
  logic               tmo;
  logic               idle;
  logic               inStart;
  logic               bufWr;

  // ------------------------------------------------------------
  // pin sampling
  // ------------------------------------------------------------
  ims_sync2 u_sync_scl (.clk(clk), .resetn(resetn), .pinIn(sclIn), .pinSync(sclS));
  ims_sync2 u_sync_sda (.clk(clk), .resetn(resetn), .pinIn(sdaIn), .pinSync(sdaS));

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  assign req     = wb_cyc_i && wb_stb_i && !q_ff.ack;
  // writes land on the ack edge, while the master still holds its request
  assign wr      = wb_cyc_i && wb_stb_i && q_ff.ack && wb_we_i && wb_sel_i[0];
  assign rd      = req && !wb_we_i;
  assign tmo     = (q_ff.baud_generator == 7'h00);
  assign idle    = (q_ff.st == ims_pkg::ST_IDLE);
  assign inStart = q_ff.startReq || q_ff.restartReq || (q_ff.st inside {ims_pkg::ST_CHECK,
                   ims_pkg::ST_HOLD, ims_pkg::RS_SCLLOW, ims_pkg::RS_SDAHIGH,
                   ims_pkg::RS_SCLREL, ims_pkg::RS_HIGH, ims_pkg::RS_SDALOW});
  assign bufWr   = wr && (wb_adr_i == ims_pkg::ADR_BUF);

  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    nxt_q     = q_ff;
    nxt_q.ack = req;
    nxt_q.baud_generator = tmo ? 7'h00 : q_ff.baud_generator - 7'h01;

    // software side: writes and clears come first so hardware sets win
    if (wr) begin
      case (wb_adr_i)
        ims_pkg::ADR_CTRL: begin
          if (!inStart) begin
            nxt_q.startReq   = wb_dat_i[ims_pkg::CT_START];
            nxt_q.restartReq = wb_dat_i[ims_pkg::CT_RESTART] && idle;
            nxt_q.rxEn       = wb_dat_i[ims_pkg::CT_RXEN] && idle;
          end
        end
        ims_pkg::ADR_BAUD: begin
          nxt_q.reload = wb_dat_i[6:0];
        end
        ims_pkg::ADR_STAT: begin
          nxt_q.write_collision_flag    = q_ff.write_collision_flag && !wb_dat_i[ims_pkg::PS_WRITE_COLLISION_FLAG];
          nxt_q.bcol    = q_ff.bcol && !wb_dat_i[ims_pkg::PS_BCOL];
          nxt_q.started = q_ff.started && !wb_dat_i[ims_pkg::PS_STARTED];
          nxt_q.intFlag = q_ff.intFlag && !wb_dat_i[ims_pkg::PS_INT];
          nxt_q.ov      = q_ff.ov && !wb_dat_i[ims_pkg::PS_OV];
        end
        ims_pkg::ADR_BUF: begin
          if (idle && !inStart && !q_ff.rxEn) begin
            nxt_q.buffer  = wb_dat_i[7:0];
            nxt_q.txSr    = wb_dat_i[7:0];
            nxt_q.bf      = 1'b1;
            nxt_q.rxMode  = 1'b0;
            nxt_q.bitCnt  = 4'h0;
            nxt_q.sclOe   = 1'b1;
            nxt_q.sdaPend = 1'b1;
            nxt_q.baud_generator     = q_ff.reload;
            nxt_q.st      = ims_pkg::BIT_LOW;
          end else begin
            nxt_q.write_collision_flag = 1'b1;
          end
        end
        default: begin
        end
      endcase
    end
    if (rd && wb_adr_i == ims_pkg::ADR_BUF && q_ff.rxMode) begin
      nxt_q.bf = 1'b0;
    end

    // bus sequencer, always on synchronised pin levels
    case (q_ff.st)
      ims_pkg::ST_IDLE: begin
        if (bufWr) begin
          nxt_q.st = nxt_q.st;
        end else if (q_ff.startReq) begin
          if (sclS && sdaS) begin
            nxt_q.baud_generator = q_ff.reload;
            nxt_q.st  = ims_pkg::ST_CHECK;
          end else begin
            nxt_q.bcol     = 1'b1;
            nxt_q.startReq = 1'b0;
          end
        end else if (q_ff.restartReq) begin
          nxt_q.sclOe = 1'b1;
          nxt_q.st    = ims_pkg::RS_SCLLOW;
        end else if (q_ff.rxEn) begin
          nxt_q.rxMode = 1'b1;
          nxt_q.bitCnt = 4'h0;
          nxt_q.sdaOe  = 1'b0;
          nxt_q.sclOe  = 1'b1;
          nxt_q.baud_generator    = q_ff.reload;
          nxt_q.st     = ims_pkg::BIT_LOW;
        end
      end
      ims_pkg::ST_CHECK: begin
        if (!sclS || (tmo && !sdaS)) begin
          nxt_q.st       = ims_pkg::ST_IDLE;
          nxt_q.bcol     = 1'b1;
          nxt_q.startReq = 1'b0;
          nxt_q.sclOe    = 1'b0;
          nxt_q.sdaOe    = 1'b0;
        end else if (tmo) begin
          nxt_q.sdaOe   = 1'b1;
          nxt_q.started = 1'b1;
          nxt_q.baud_generator     = q_ff.reload;
          nxt_q.st      = ims_pkg::ST_HOLD;
        end
      end
      ims_pkg::ST_HOLD: begin
        if (tmo) begin
          nxt_q.startReq = 1'b0;
          nxt_q.intFlag  = 1'b1;
          nxt_q.sclOe    = 1'b1;
          nxt_q.st       = ims_pkg::ST_IDLE;
        end
      end
      ims_pkg::RS_SCLLOW: begin
        if (!sclS) begin
          nxt_q.baud_generator   = q_ff.reload;
          nxt_q.sdaOe = 1'b0;
          nxt_q.st    = ims_pkg::RS_SDAHIGH;
        end
      end
      ims_pkg::RS_SDAHIGH: begin
        if (tmo && sdaS) begin
          nxt_q.sclOe = 1'b0;
          nxt_q.st    = ims_pkg::RS_SCLREL;
        end
      end
      ims_pkg::RS_SCLREL: begin
        if (sclS && !sdaS) begin
          nxt_q.st         = ims_pkg::ST_IDLE;
          nxt_q.bcol       = 1'b1;
          nxt_q.restartReq = 1'b0;
          nxt_q.sclOe      = 1'b0;
          nxt_q.sdaOe      = 1'b0;
        end else if (sclS) begin
          nxt_q.baud_generator = q_ff.reload;
          nxt_q.st  = ims_pkg::RS_HIGH;
        end
      end
      ims_pkg::RS_HIGH: begin
        if (!sclS || !sdaS) begin
          nxt_q.st         = ims_pkg::ST_IDLE;
          nxt_q.bcol       = 1'b1;
          nxt_q.restartReq = 1'b0;
          nxt_q.sclOe      = 1'b0;
          nxt_q.sdaOe      = 1'b0;
        end else if (tmo) begin
          nxt_q.sdaOe   = 1'b1;
          nxt_q.started = 1'b1;
          nxt_q.baud_generator     = q_ff.reload;
          nxt_q.st      = ims_pkg::RS_SDALOW;
        end
      end
      ims_pkg::RS_SDALOW: begin
        if (tmo) begin
          nxt_q.restartReq = 1'b0;
          nxt_q.intFlag    = 1'b1;
          nxt_q.sclOe      = 1'b1;
          nxt_q.st         = ims_pkg::ST_IDLE;
        end
      end
      ims_pkg::BIT_LOW: begin
        // data moves one cycle after SCL is pulled low, never while high
        if (q_ff.sdaPend && !q_ff.rxMode) begin
          nxt_q.sdaPend = 1'b0;
          nxt_q.sdaOe   = (q_ff.bitCnt == ims_pkg::ACK_BIT) ? 1'b0 : !q_ff.txSr[7];
          nxt_q.txSr    = {q_ff.txSr[6:0], 1'b0};
        end
        if (tmo) begin
          nxt_q.sclOe = 1'b0;
          nxt_q.st    = ims_pkg::BIT_HWAIT;
        end
      end
      ims_pkg::BIT_HWAIT: begin
        // a slave stretching SCL delays the high period
        if (sclS) begin
          nxt_q.baud_generator = q_ff.reload;
          nxt_q.st  = ims_pkg::BIT_HIGH;
        end
      end
      ims_pkg::BIT_HIGH: begin
        if (tmo) begin
          nxt_q.sclOe   = 1'b1;
          nxt_q.baud_generator     = q_ff.reload;
          nxt_q.bitCnt  = q_ff.bitCnt + 4'h1;
          nxt_q.sdaPend = 1'b1;
          nxt_q.st      = ims_pkg::BIT_LOW;
          if (q_ff.rxMode) begin
            nxt_q.rxSr = {q_ff.rxSr[6:0], sdaS};
            if (q_ff.bitCnt == ims_pkg::LAST_DATA) begin
              nxt_q.rxEn    = 1'b0;
              nxt_q.buffer  = {q_ff.rxSr[6:0], sdaS};
              nxt_q.bf      = 1'b1;
              nxt_q.ov      = q_ff.ov || q_ff.bf;
              nxt_q.intFlag = 1'b1;
              nxt_q.st      = ims_pkg::ST_IDLE;
            end
          end else if (q_ff.bitCnt == ims_pkg::LAST_DATA) begin
            nxt_q.bf = 1'b0;
          end else if (q_ff.bitCnt == ims_pkg::ACK_BIT) begin
            nxt_q.ack_status = sdaS;
            nxt_q.intFlag = 1'b1;
            nxt_q.sdaPend = 1'b0;
            nxt_q.st      = ims_pkg::ST_IDLE;
          end
        end
      end
      default: begin
        nxt_q.st = ims_pkg::ST_IDLE;
      end
    endcase

    // read data
    nxt_q.rdat = 32'h0000_0000;
    if (rd) begin
      case (wb_adr_i)
        ims_pkg::ADR_CTRL: begin
          nxt_q.rdat[ims_pkg::CT_START]   = q_ff.startReq;
          nxt_q.rdat[ims_pkg::CT_RESTART] = q_ff.restartReq;
          nxt_q.rdat[ims_pkg::CT_RXEN]    = q_ff.rxEn;
          nxt_q.rdat[ims_pkg::CT_ACK_STATUS] = q_ff.ack_status;
        end
        ims_pkg::ADR_BAUD: begin
          nxt_q.rdat[6:0] = q_ff.reload;
        end
        ims_pkg::ADR_STAT: begin
          nxt_q.rdat[ims_pkg::PS_BF]      = q_ff.bf;
          nxt_q.rdat[ims_pkg::PS_WRITE_COLLISION_FLAG]    = q_ff.write_collision_flag;
          nxt_q.rdat[ims_pkg::PS_BCOL]    = q_ff.bcol;
          nxt_q.rdat[ims_pkg::PS_STARTED] = q_ff.started;
          nxt_q.rdat[ims_pkg::PS_INT]     = q_ff.intFlag;
          nxt_q.rdat[ims_pkg::PS_OV]      = q_ff.ov;
        end
        ims_pkg::ADR_BUF: begin
          nxt_q.rdat[7:0] = q_ff.buffer;
        end
        default: begin
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!resetn) begin
      q_ff        <= '0;
      q_ff.st     <= ims_pkg::ST_IDLE;
      q_ff.reload <= ims_pkg::BAUD_RST;
    end else begin
      q_ff <= nxt_q;
    end
  end

  // ------------------------------------------------------------
  // outputs: lines are only ever pulled low or released
  // ------------------------------------------------------------
  assign sclOut   = 1'b0;
  assign sdaOut   = 1'b0;
  assign sclOe    = q_ff.sclOe;
  assign sdaOe    = q_ff.sdaOe;
  assign wb_ack_o = q_ff.ack;
  assign wb_dat_o = q_ff.rdat;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  a_start_edge: assert property (
    q_ff.st == ims_pkg::ST_CHECK && tmo && sclS && sdaS
    |=> sdaOe && q_ff.started && q_ff.st == ims_pkg::ST_HOLD)
    else $error("start edge not driven at baud timeout");
  a_start_collide: assert property (
    idle && q_ff.startReq && !bufWr && !(sclS && sdaS)
    |=> q_ff.bcol && !q_ff.startReq && idle)
    else $error("start on busy lines did not flag collision");
  a_write_collision_flag_busy: assert property (
    bufWr && !idle |=> q_ff.write_collision_flag && $stable(q_ff.buffer))
    else $error("busy buffer write not refused");
  a_write_collision_flag_sticky: assert property (
    q_ff.write_collision_flag && !(wr && wb_adr_i == ims_pkg::ADR_STAT && wb_dat_i[ims_pkg::PS_WRITE_COLLISION_FLAG])
    |=> q_ff.write_collision_flag)
    else $error("write collision cleared by hardware");
  a_restart_gate: assert property (
    wr && wb_adr_i == ims_pkg::ADR_CTRL && !idle && !q_ff.restartReq
    |=> !q_ff.restartReq)
    else $error("restart request taken while busy");
  a_tx_start: assert property (
    bufWr && idle && !inStart && !q_ff.rxEn
    |=> q_ff.bf && q_ff.st == ims_pkg::BIT_LOW ##1 sclOe)
    else $error("buffer write did not start transmit");
  a_ack_sample: assert property (
    q_ff.st == ims_pkg::BIT_HIGH && tmo && !q_ff.rxMode && q_ff.bitCnt == ims_pkg::ACK_BIT
    |=> q_ff.ack_status == $past(sdaS) && q_ff.intFlag && idle && sclOe)
    else $error("acknowledge not captured at ninth clock");
  a_rx_done: assert property (
    q_ff.st == ims_pkg::BIT_HIGH && tmo && q_ff.rxMode && q_ff.bitCnt == ims_pkg::LAST_DATA
    |=> q_ff.bf && !q_ff.rxEn && q_ff.intFlag && idle && sclOe)
    else $error("received byte not completed");
  a_rx_overflow: assert property (
    q_ff.st == ims_pkg::BIT_HIGH && tmo && q_ff.rxMode
    && q_ff.bitCnt == ims_pkg::LAST_DATA && q_ff.bf
    |=> q_ff.ov)
    else $error("overflow not flagged");
endmodule

// >>> src/ims_pkg.sv
// constants and types for the two-wire bus master sequencer
package ims_pkg;
  // ------------------------------------------------------------
  // register byte offsets on the bus
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL = 8'h00;
  localparam logic [7:0] ADR_BAUD = 8'h04;
  localparam logic [7:0] ADR_STAT = 8'h08;
  localparam logic [7:0] ADR_BUF  = 8'h0C;

  // ------------------------------------------------------------
  // control_two field positions
  // ------------------------------------------------------------
  localparam int CT_START   = 0;
  localparam int CT_RESTART = 1;
  localparam int CT_RXEN    = 3;
  localparam int CT_ACK_STATUS = 6;

  // ------------------------------------------------------------
  // port_status field positions
  // ------------------------------------------------------------
  localparam int PS_BF      = 0;
  localparam int PS_WRITE_COLLISION_FLAG    = 1;
  localparam int PS_BCOL    = 2;
  localparam int PS_STARTED = 3;
  localparam int PS_INT     = 4;
  localparam int PS_OV      = 5;

  // ------------------------------------------------------------
  // reset values and counts
  // ------------------------------------------------------------
  localparam logic [6:0] BAUD_RST  = 7'h13;
  localparam logic [3:0] LAST_DATA = 4'h7;
  localparam logic [3:0] ACK_BIT   = 4'h8;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_CHECK   = 4'h1,
    ST_HOLD    = 4'h2,
    RS_SCLLOW  = 4'h3,
    RS_SDAHIGH = 4'h4,
    RS_SCLREL  = 4'h5,
    RS_HIGH    = 4'h6,
    RS_SDALOW  = 4'h7,
    BIT_LOW    = 4'h8,
    BIT_HWAIT  = 4'h9,
    BIT_HIGH   = 4'hA
  } ims_state_t;

  typedef struct packed {
    logic meta;
    logic sync;
  } ims_sync_t;

  typedef struct packed {
    ims_state_t  st;
    logic [6:0]  baud_generator;
    logic [6:0]  reload;
    logic        sclOe;
    logic        sdaOe;
    logic        sdaPend;
    logic [3:0]  bitCnt;
    logic [7:0]  txSr;
    logic [7:0]  rxSr;
    logic [7:0]  buffer;
    logic        startReq;
    logic        restartReq;
    logic        rxEn;
    logic        ack_status;
    logic        bf;
    logic        write_collision_flag;
    logic        bcol;
    logic        started;
    logic        intFlag;
    logic        ov;
    logic        rxMode;
    logic        ack;
    logic [31:0] rdat;
  } ims_regs_t;
endpackage

// >>> src/ims_sync2.sv
// two-flop synchroniser for one bus pin level
`timescale 1ns/1ps
module ims_sync2 (
  input  wire logic clk,
  input  wire logic resetn,
  input  wire logic pinIn,
  output logic      pinSync
);
  ims_pkg::ims_sync_t q_ff;
  ims_pkg::ims_sync_t nxt_q;

  always_comb begin
    nxt_q      = q_ff;
    nxt_q.meta = pinIn;
    nxt_q.sync = q_ff.meta;
  end

  // released bus idles high, so the chain resets high
  always_ff @(posedge clk) begin
    if (!resetn) begin
      q_ff <= '{meta: 1'b1, sync: 1'b1};
    end else begin
      q_ff <= nxt_q;
    end
  end

  assign pinSync = q_ff.sync;
endmodule

// >>> dv/ims_slave_model.sv
// behavioural slave device on the two-wire bus
`timescale 1ns/1ps
module ims_slave_model (
  input  wire logic       scl,
  input  wire logic       sda,
  input  wire logic       ackEn,
  input  wire logic       rxMode,
  input  wire logic       stretch,
  input  wire logic [7:0] txByte,
  output logic            sclOe,
  output logic            sdaOe,
  output logic [7:0]      rxByte
);
  int cnt = 0;
  initial sclOe = 1'b0;
  initial rxByte = 8'h00;
  // ------------------------------------------------------------
  // framing
  // ------------------------------------------------------------
  // start edge re-arms, so the master's own scl fall is not a bit
  always @(negedge sda) if (scl) cnt = -1;
  always @(posedge scl) if (!rxMode && cnt >= 0 && cnt < 8) rxByte = {rxByte[6:0], sda};
  always @(negedge scl) cnt = (cnt == 8 || (rxMode && cnt == 7)) ? 0 : cnt + 1;
  // slow answer: hold scl low a while after each fall
  always @(negedge scl) if (stretch) begin
    sclOe <= 1'b1;
    sclOe <= #1000 1'b0;
  end
  // ack during ninth bit, or data while the master receives
  assign sdaOe = rxMode ? (cnt >= 0 && cnt < 8 && !txByte[7-cnt]) : (cnt == 8 && ackEn);
endmodule

// >>> dv/ims_master_bench.sv
// random and directed bench for the two-wire bus master sequencer
`timescale 1ns/1ps
`define CHK(nm, e, g) begin checkCount++; if ((g) !== (e)) begin errCount++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module ims_master_bench;
  logic        clk = 1'b0;
  logic        resetn = 1'b0;
  logic        cyc = 1'b0;
  logic        we = 1'b0;
  logic [3:0]  sel = 4'h0;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic [31:0] rd;
  logic        ack;
  logic        sclOut;
  logic        sclOe;
  logic        sdaOut;
  logic        sdaOe;
  logic        busLow = 1'b0;
  logic        ackEn = 1'b1;
  logic        rxMode = 1'b0;
  logic        stretch = 1'b0;
  logic [7:0]  txByte = 8'h00;
  logic [7:0]  rxByte;
  logic [7:0]  val;
  logic        sSclOe;
  logic        sSdaOe;
  int          errCount = 0;
  int          checkCount = 0;
  // pull-up wires: any driver or a stuck bus pulls low
  wire sclW = !(sclOe | sSclOe | busLow);
  wire sdaW = !(sdaOe | sSdaOe | busLow);

  ims_master uut (.clk(clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .sclIn(sclW), .sclOut(sclOut), .sclOe(sclOe), .sdaIn(sdaW), .sdaOut(sdaOut), .sdaOe(sdaOe));
  ims_slave_model slave (.scl(sclW), .sda(sdaW), .ackEn(ackEn), .rxMode(rxMode),
    .stretch(stretch), .txByte(txByte), .sclOe(sSclOe), .sdaOe(sSdaOe), .rxByte(rxByte));

  initial forever #12.5 clk = ~clk;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [31:0] bitv(input int p);
    return 32'h1 << p;
  endfunction

  task automatic wbCyc(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    sel  <= 4'hF;
    adr  <= a;
    wdat <= d;
    // no answer time assumed: only the watchdog ends a lost answer
    do begin
      @(posedge clk);
    end while (ack !== 1'b1);
    rd = rdat;
    cyc <= 1'b0;
    we  <= 1'b0;
    sel <= 4'h0;
  endtask

  // poll one status bit; the watchdog bounds a hang
  task automatic waitStat(input int pos);
    do begin
      wbCyc(1'b0, ims_pkg::ADR_STAT, 32'h0);
    end while (rd[pos] !== 1'b1);
  endtask

  task automatic completeRun();
    if (errCount == 0 && checkCount > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  initial begin
    #(25 * 60000);
    errCount++;
    completeRun();
  end

  // ------------------------------------------------------------
  // tests
  // ------------------------------------------------------------
  initial begin
    void'($urandom(32'h59d1));
    repeat (4) @(posedge clk);
    resetn <= 1'b1;
    wbCyc(1'b0, ims_pkg::ADR_CTRL, 32'h0);
    `CHK("ctrl reset", 32'h0, rd)
    wbCyc(1'b0, ims_pkg::ADR_BAUD, 32'h0);
    `CHK("baud reset", {25'h0, ims_pkg::BAUD_RST}, rd)
    wbCyc(1'b0, 8'h10, 32'h0);
    `CHK("unmapped", 32'h0, rd)
    // start on a stuck-low bus must collide without pin activity
    busLow <= 1'b1;
    wbCyc(1'b1, ims_pkg::ADR_CTRL, bitv(ims_pkg::CT_START));
    repeat (20) @(posedge clk);
    wbCyc(1'b0, ims_pkg::ADR_STAT, 32'h0);
    `CHK("bcol", 1'b1, rd[ims_pkg::PS_BCOL])
    `CHK("no drive", 2'b00, {sclOe, sdaOe})
    `CHK("drive level", 2'b00, {sclOut, sdaOut})
    busLow <= 1'b0;
    wbCyc(1'b1, ims_pkg::ADR_STAT, 32'h3E);
    // at least four cycles a period, so the start still runs at the lock check
    wbCyc(1'b1, ims_pkg::ADR_BAUD, 32'($urandom_range(5, 3)));
    wbCyc(1'b1, ims_pkg::ADR_CTRL, bitv(ims_pkg::CT_START));
    wbCyc(1'b1, ims_pkg::ADR_BUF, 32'hA5);
    wbCyc(1'b1, ims_pkg::ADR_CTRL, 32'h1E);
    wbCyc(1'b0, ims_pkg::ADR_CTRL, 32'h0);
    `CHK("ctrl locked", bitv(ims_pkg::CT_START), rd)
    waitStat(ims_pkg::PS_INT);
    `CHK("started", 1'b1, rd[ims_pkg::PS_STARTED])
    `CHK("write_collision_flag start", 1'b1, rd[ims_pkg::PS_WRITE_COLLISION_FLAG])
    `CHK("start pins", 2'b11, {sclOe, sdaOe})
    wbCyc(1'b0, ims_pkg::ADR_CTRL, 32'h0);
    `CHK("ctrl after start", 32'h0, rd)
    wbCyc(1'b0, ims_pkg::ADR_BUF, 32'h0);
    `CHK("buf kept", 32'h0, rd)
    // bytes: acked, refused, acked with a stretching slave
    for (int i = 0; i < 3; i++) begin
      val = 8'($urandom);
      ackEn <= (i != 1);
      stretch <= (i == 2);
      wbCyc(1'b1, ims_pkg::ADR_STAT, 32'h3E);
      wbCyc(1'b1, ims_pkg::ADR_BUF, {24'h0, val});
      wbCyc(1'b0, ims_pkg::ADR_STAT, 32'h0);
      `CHK("bf set", 1'b1, rd[ims_pkg::PS_BF])
      wbCyc(1'b1, ims_pkg::ADR_BUF, {24'h0, ~val});
      wbCyc(1'b1, ims_pkg::ADR_CTRL, 32'h0A);
      waitStat(ims_pkg::PS_INT);
      `CHK("bf clear", 1'b0, rd[ims_pkg::PS_BF])
      `CHK("write_collision_flag held", 1'b1, rd[ims_pkg::PS_WRITE_COLLISION_FLAG])
      `CHK("slave byte", val, rxByte)
      `CHK("scl held", 1'b1, sclOe)
      wbCyc(1'b0, ims_pkg::ADR_CTRL, 32'h0);
      `CHK("ack status", {(i == 1), 2'b00}, {rd[6], rd[1], rd[3]})
      wbCyc(1'b0, ims_pkg::ADR_BUF, 32'h0);
      `CHK("tx buf", {24'h0, val}, rd)
    end
    stretch <= 1'b0;
    wbCyc(1'b1, ims_pkg::ADR_STAT, 32'h3E);
    wbCyc(1'b1, ims_pkg::ADR_CTRL, bitv(ims_pkg::CT_RESTART));
    waitStat(ims_pkg::PS_INT);
    `CHK("restart seen", 1'b1, rd[ims_pkg::PS_STARTED])
    `CHK("restart pins", 2'b11, {sclOe, sdaOe})
    wbCyc(1'b0, ims_pkg::ADR_CTRL, 32'h0);
    `CHK("restart cleared", 1'b0, rd[ims_pkg::CT_RESTART])
    // receive three bytes, leave the middle one unread
    rxMode <= 1'b1;
    for (int j = 0; j < 3; j++) begin
      txByte <= 8'($urandom);
      wbCyc(1'b1, ims_pkg::ADR_STAT, 32'h3E);
      wbCyc(1'b1, ims_pkg::ADR_CTRL, bitv(ims_pkg::CT_RXEN));
      waitStat(ims_pkg::PS_INT);
      `CHK("rx bf", 1'b1, rd[ims_pkg::PS_BF])
      `CHK("overflow", (j == 2), rd[ims_pkg::PS_OV])
      wbCyc(1'b0, ims_pkg::ADR_CTRL, 32'h0);
      `CHK("rxen cleared", 1'b0, rd[ims_pkg::CT_RXEN])
      `CHK("rx scl low", 1'b1, sclOe)
      if (j != 1) begin
        wbCyc(1'b0, ims_pkg::ADR_BUF, 32'h0);
        `CHK("rx byte", {24'h0, txByte}, rd)
        wbCyc(1'b0, ims_pkg::ADR_STAT, 32'h0);
        `CHK("bf read clear", 1'b0, rd[ims_pkg::PS_BF])
      end
    end
    completeRun();
  end
endmodule
